//--- bench/hss_status_test.sv
`default_nettype none
module hss_status_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rst, wr, rd, run, async_sched_enable, periodic_sched_enable, tick, idle, empty, evdb, dback;
	logic rdv, halted, exp_v, m_halt, m_as, m_ps, m_empty_async_detect, m_db, hit;
	logic [31:0] base, addr, wdata, rdata, exp_rd, stat, r;
	logic [4:0] evt, ev;
	int err_total;
	int checks_done;
	hss_status i_hss_status (
		.I_REF_CLK(clk), .I_SYS_RST(rst), .I_BASE_ADDR(base), .I_ADDR(addr),
		.I_WR(wr), .I_RD(rd), .I_WDATA(wdata), .I_RUN_STOP_CTRL(run),
		.I_ASYNC_SCHED_ENABLE(async_sched_enable), .I_PERIODIC_SCHED_ENABLE(periodic_sched_enable),
		.I_SCHED_TICK(tick), .I_PIPE_IDLE(idle), .I_EMPTY_ASYNC_DETECT(empty),
		.I_EVT_DOORBELL(evdb), .I_DOORBELL_ACK(dback), .I_EVT(evt),
		.O_RDATA(rdata), .O_RD_VALID(rdv), .O_CONTROLLER_HALTED(halted)
	);
	initial begin
		clk = 1'h0;
		forever #12.5 clk = ~clk;
	end
	assign hit = addr == base + hss_pkg::STATUS_OFFSET;
	assign stat = {16'h0, m_as, m_ps, m_empty_async_detect, m_halt, 6'h0, m_db, ev};
	// reference model, one step per rising edge
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			{exp_v, m_as, m_ps, m_empty_async_detect, m_db, ev} <= 10'h0;
			exp_rd <= 32'h0;
			m_halt <= 1'h1;
		end else begin
			exp_v <= rd && hit;
			exp_rd <= (rd && hit) ? stat : 32'h0;
			ev <= (ev & ~((wr && hit) ? wdata[4:0] : 5'h0)) | evt;
			m_db <= evdb || (m_db && !dback);
			m_empty_async_detect <= empty;
			if (tick) begin
				m_as <= async_sched_enable;
				m_ps <= periodic_sched_enable;
			end
			if (run)
				m_halt <= 1'h0;
			else if (idle)
				m_halt <= 1'h1;
		end
	end
	task chk(input string name, input logic [31:0] seen,
		input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_total++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk
	task stop_test;
		if (err_total == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : stop_test
	// quiet inputs with a read of the status word
	task quiet;
		{wr, run, async_sched_enable, periodic_sched_enable, tick, empty, evdb, dback, evt} = 13'h0;
		{rd, idle} = 2'h3;
		addr = base + hss_pkg::STATUS_OFFSET;
		wdata = 32'h0;
	endtask : quiet
	task step;
		r = $urandom;
		{rd, wr, idle, async_sched_enable, periodic_sched_enable, empty} = r[5:0];
		if (r[8:6] == 3'h0)
			run = ~run;
		tick = r[10:9] == 2'h0;
		evdb = r[13:11] == 3'h0;
		dback = r[16:14] == 3'h0;
		evt = r[21:17] & r[26:22];
		case (r[29:27])
			3'h0: addr = base + 32'h20;
			3'h1: addr = base + 32'h25;
			default: addr = base + hss_pkg::STATUS_OFFSET;
		endcase
		wdata = $urandom & 32'h0000_f03f;
	endtask : step
	initial begin
		void'($urandom(32'h1f66a510));
		err_total = 0;
		checks_done = 0;
		base = $urandom & 32'hffff_ff00;
		rst = 1'h1;
		quiet();
		repeat (12) @(negedge clk);
		for (int n = 0; n < 3000; n++) begin
			@(negedge clk);
			chk("read_valid", {31'h0, rdv}, {31'h0, exp_v});
			chk("read_data", rdata, exp_rd);
			chk("halted", {31'h0, halted}, {31'h0, m_halt});
			if (n == 1 || n == 1500)
				chk("reset_word", rdata, hss_pkg::STATUS_RESET);
			rst = n == 1498;
			if (n == 0 || n == 1499)
				quiet();
			else
				step();
		end
		stop_test();
	end
endmodule : hss_status_test
`default_nettype wire

//--- design/hss_flag.sv
`default_nettype none
module hss_flag (
	input wire logic i_clk, // core clock
	input wire logic i_rst, // async reset, active high
	input wire logic i_set, // hardware event pulse
	input wire logic i_clr, // clear pulse
	output logic o_flag // sticky flag
);
	// set wins over a clear in the same cycle
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_flag <= hss_pkg::RST_FLAG;
		end else if (i_set) begin
			o_flag <= 1'h1;
		end else if (i_clr) begin
			o_flag <= 1'h0;
		end
	end
endmodule : hss_flag
`default_nettype wire

//--- design/hss_status.sv
`default_nettype none
module hss_status (
	input wire logic I_REF_CLK, // 40 MHz core clock
	input wire logic I_SYS_RST, // async reset, active high
	input wire logic [31:0] I_BASE_ADDR, // memory base address register
	input wire logic [31:0] I_ADDR, // access byte address
	input wire logic I_WR, // write strobe
	input wire logic I_RD, // read strobe
	input wire logic [31:0] I_WDATA, // write data
	input wire logic I_RUN_STOP_CTRL, // run/stop from command register
	input wire logic I_ASYNC_SCHED_ENABLE, // async enable from command reg
	input wire logic I_PERIODIC_SCHED_ENABLE, // periodic enable
	input wire logic I_SCHED_TICK, // schedule boundary pulse
	input wire logic I_PIPE_IDLE, // no active transactions in pipeline
	input wire logic I_EMPTY_ASYNC_DETECT, // empty async schedule seen
	input wire logic I_EVT_DOORBELL, // doorbell advance event pulse
	input wire logic I_DOORBELL_ACK, // core clears doorbell flag
	input wire logic [4:0] I_EVT, // event pulses for bits 4..0
	output logic [31:0] O_RDATA, // read data
	output logic O_RD_VALID, // read answer pulse
	output logic O_CONTROLLER_HALTED // halted state
);
	logic hit;
	logic [4:0] evt_flag;
	logic [4:0] clr;
	logic async_sched_state;
	logic periodic_sched_state;
	logic empty_async_detect;
	logic controller_halted;
	logic doorbell_advance_flag;
	logic [31:0] host_status;
	logic [31:0] next_rdata;

	assign hit = (I_ADDR == 32'(I_BASE_ADDR + hss_pkg::STATUS_OFFSET));

	// writable event bits clear where a one is written
	assign clr = (I_WR && hit) ? I_WDATA[4:0] : 5'h00;

	genvar g;
	generate
		for (g = 0; g < hss_pkg::NUM_EVENTS; g++) begin : g_evt
			hss_flag u_flag (
				.i_clk(I_REF_CLK),
				.i_rst(I_SYS_RST),
				.i_set(I_EVT[g]),
				.i_clr(clr[g]),
				.o_flag(evt_flag[g])
			);
		end
	endgenerate

	// schedule states take the enable only at a schedule boundary
	always_ff @(posedge I_REF_CLK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			async_sched_state <= hss_pkg::RST_FLAG;
			periodic_sched_state <= hss_pkg::RST_FLAG;
		end else if (I_SCHED_TICK) begin
			async_sched_state <= I_ASYNC_SCHED_ENABLE;
			periodic_sched_state <= I_PERIODIC_SCHED_ENABLE;
		end
	end

	always_ff @(posedge I_REF_CLK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			empty_async_detect <= hss_pkg::RST_FLAG;
		end else begin
			empty_async_detect <= I_EMPTY_ASYNC_DETECT;
		end
	end

	// halt only after the pipeline has drained
	always_ff @(posedge I_REF_CLK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			controller_halted <= hss_pkg::RST_HALTED;
		end else if (I_RUN_STOP_CTRL) begin
			controller_halted <= 1'h0;
		end else if (I_PIPE_IDLE) begin
			controller_halted <= 1'h1;
		end
	end

	// doorbell flag is not cleared by software writes
	always_ff @(posedge I_REF_CLK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			doorbell_advance_flag <= hss_pkg::RST_FLAG;
		end else if (I_EVT_DOORBELL) begin
			doorbell_advance_flag <= 1'h1;
		end else if (I_DOORBELL_ACK) begin
			doorbell_advance_flag <= 1'h0;
		end
	end

	always_comb begin
		host_status = 32'h0000_0000;
		host_status[hss_pkg::BIT_ASYNC_STATE] = async_sched_state;
		host_status[hss_pkg::BIT_PERIODIC_STATE] = periodic_sched_state;
		host_status[hss_pkg::BIT_EMPTY_ASYNC] = empty_async_detect;
		host_status[hss_pkg::BIT_HALTED] = controller_halted;
		host_status[hss_pkg::BIT_DOORBELL] = doorbell_advance_flag;
		host_status[4:0] = evt_flag;
	end

	assign next_rdata = (I_RD && hit) ? host_status : 32'h0000_0000;

	always_ff @(posedge I_REF_CLK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			O_RDATA <= 32'h0000_0000;
			O_RD_VALID <= 1'h0;
		end else begin
			O_RDATA <= next_rdata;
			O_RD_VALID <= I_RD && hit;
		end
	end

	always_ff @(posedge I_REF_CLK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			O_CONTROLLER_HALTED <= hss_pkg::RST_HALTED;
		end else begin
			O_CONTROLLER_HALTED <= next_halt_out();
		end
	end

	function automatic logic next_halt_out();
		if (I_RUN_STOP_CTRL) begin
			return 1'h0;
		end
		return controller_halted | I_PIPE_IDLE;
	endfunction : next_halt_out

	// helper for the reset value check
	logic seen;
	always_ff @(posedge I_REF_CLK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			seen <= 1'h0;
		end else begin
			seen <= 1'h1;
		end
	end

	default clocking cb @(posedge I_REF_CLK);
	endclocking
	default disable iff (I_SYS_RST);

	a_decode_hit: assert property ((I_RD && hit) |=> O_RD_VALID)
		else $error("read of status offset not answered");
	a_decode_miss: assert property ((I_RD && !hit) |=> !O_RD_VALID)
		else $error("read of other offset answered");
	a_idle_rdata: assert property (
		!(I_RD && hit) |=> O_RDATA == 32'h0000_0000)
		else $error("read data not zero outside an answer");
	a_w1c_clear: assert property (
		(I_WR && hit && I_WDATA[0] && !I_EVT[0]) |=> !evt_flag[0])
		else $error("write of one did not clear event bit");
	a_w1c_keep: assert property (
		(I_WR && hit && !I_WDATA[1] && evt_flag[1]) |=> evt_flag[1])
		else $error("write of zero cleared event bit");
	a_set_wins: assert property (
		(I_EVT[2] && I_WR && hit && I_WDATA[2]) |=> evt_flag[2])
		else $error("event lost to simultaneous clear");
	a_event_cause: assert property (
		$rose(evt_flag[3]) |-> $past(I_EVT[3]))
		else $error("event flag set without its cause");
	a_event_set: assert property (I_EVT[4] |=> evt_flag[4])
		else $error("event pulse did not set its flag");
	a_reserved_zero: assert property (O_RD_VALID |->
		(O_RDATA[31:16] == 16'h0000) && (O_RDATA[11:6] == 6'h00))
		else $error("reserved bits read nonzero");
	a_halt_read: assert property (O_RD_VALID |->
		O_RDATA[12] == $past(controller_halted))
		else $error("halted flag misplaced in read data");
	a_bit_map: assert property (O_RD_VALID |->
		O_RDATA[5:0] == $past(host_status[5:0]))
		else $error("event bits misplaced in read data");
	a_reset_value: assert property (!seen |->
		host_status == hss_pkg::STATUS_RESET)
		else $error("status not at reset value");
	a_async_lag: assert property (
		$changed(async_sched_state) |-> $past(I_SCHED_TICK) &&
		async_sched_state == $past(I_ASYNC_SCHED_ENABLE))
		else $error("async state moved off a boundary");
	a_periodic_lag: assert property (
		$changed(periodic_sched_state) |-> $past(I_SCHED_TICK) &&
		periodic_sched_state == $past(I_PERIODIC_SCHED_ENABLE))
		else $error("periodic state moved off a boundary");
	a_halt_drain: assert property ($rose(controller_halted) |->
		$past(!I_RUN_STOP_CTRL && I_PIPE_IDLE))
		else $error("halted set before pipeline drained");
	a_halt_run: assert property (
		I_RUN_STOP_CTRL |=> !controller_halted)
		else $error("halted kept while running");
	a_halt_pin: assert property (
		O_CONTROLLER_HALTED == controller_halted)
		else $error("halted output differs from status bit");
	a_empty_copy: assert property (
		I_EMPTY_ASYNC_DETECT |=> empty_async_detect)
		else $error("empty schedule indication not copied");
	a_ro_doorbell: assert property ((I_WR && hit && I_WDATA[5] &&
		!I_DOORBELL_ACK && !I_EVT_DOORBELL) |=> $stable(doorbell_advance_flag))
		else $error("write altered doorbell flag");

	c_clear: cover property (I_WR && hit && |(I_WDATA[4:0] & evt_flag));
	c_halt: cover property ((!I_RUN_STOP_CTRL && !I_PIPE_IDLE) ##1
		(!I_RUN_STOP_CTRL && I_PIPE_IDLE) ##1 $rose(controller_halted));
	c_async_on: cover property ($rose(async_sched_state));
	c_read: cover property (I_RD && hit ##1 O_RDATA[0]);
	c_doorbell_ack: cover property (doorbell_advance_flag ##1
		!doorbell_advance_flag);
endmodule : hss_status
`default_nettype wire

//--- inc/hss_pkg.sv
`default_nettype none
package hss_pkg;
	localparam logic [31:0] STATUS_OFFSET = 32'h0000_0024;
	localparam logic [31:0] STATUS_RESET = 32'h0000_1000;
	localparam int BIT_ASYNC_STATE = 15;
	localparam int BIT_PERIODIC_STATE = 14;
	localparam int BIT_EMPTY_ASYNC = 13;
	localparam int BIT_HALTED = 12;
	localparam int BIT_DOORBELL = 5;
	localparam int BIT_SYS_ERR = 4;
	localparam int BIT_ROLLOVER = 3;
	localparam int BIT_PORT_CHG = 2;
	localparam int BIT_XFER_ERR = 1;
	localparam int BIT_XFER_DONE = 0;
	localparam int NUM_EVENTS = 5;
	localparam logic RST_HALTED = 1'h1;
	localparam logic RST_FLAG = 1'h0;
endpackage : hss_pkg
`default_nettype wire
